// ===== sscr_bus_arbiter.sv
// Arbiter between the internal processor and SPI on the register bus.
// Assumes both requesters hold their request until granted.
`timescale 1ns/1ns
module sscr_bus_arbiter (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Hold control
	input  wire logic        hold,
	// Processor side
	input  wire logic        cpu_req,
	input  wire logic [15:0] cpu_addr,
	output logic             cpu_grant,
	// SPI side
	input  wire logic        spi_req,
	input  wire logic [15:0] spi_addr,
	output logic             spi_grant
);
	logic conflict;
	logic spi_grant_next;
	logic cpu_grant_next;

	always_comb
	begin
		conflict = cpu_req && (sscr_pkg::submod_of(cpu_addr) == sscr_pkg::submod_of(spi_addr));
		// Processor stalled while held
		cpu_grant_next = cpu_req && !hold && !cpu_grant;
		// SPI waits on a busy shared sub-bus unless held
		spi_grant_next = spi_req && !spi_grant && (hold || !conflict);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cpu_grant <= 1'b0;
			spi_grant <= 1'b0;
		end
		else
		begin
			cpu_grant <= cpu_grant_next;
			spi_grant <= spi_grant_next;
		end
	end
endmodule

// ===== sscr_host_model.sv
// Host side model making register accesses on request of the bench.
// Assumes the register block grants each held request once, on clk_sys.
`timescale 1ns/1ns
module sscr_host_model (
	// Clock
	input  wire logic        clk_sys,
	// Register access
	output logic             spi_req,
	output logic             spi_we,
	output logic [15:0]      spi_addr,
	output logic [7:0]       spi_wdata,
	input  wire logic        spi_grant,
	input  wire logic [7:0]  spi_rdata
);
	initial
	begin
		spi_req   = 1'h0;
		spi_we    = 1'h0;
		spi_addr  = 16'h0000;
		spi_wdata = 8'h00;
	end

	// One access, held until the grant edge, dropped the cycle after
	task automatic xfer(input logic we, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output bit ok);
		int n;
		ok        = 1'b0;
		spi_req   = 1'h1;
		spi_we    = we;
		spi_addr  = a;
		spi_wdata = d;
		for (n = 0; n < 64 && !ok; n++)
		begin
			@(negedge clk_sys);
			ok = (spi_grant === 1'h1);
		end
		@(negedge clk_sys);
		q = spi_rdata;
		// Released lines show the inverse of the last value
		spi_req   = 1'h0;
		spi_we    = ~we;
		spi_addr  = ~a;
		spi_wdata = ~d;
		@(negedge clk_sys);
	endtask

	// Last transfer of a held transaction gives the bus back
	task automatic release_hold(output bit ok);
		logic [7:0] q;
		xfer(1'h1, sscr_pkg::ADDR_SPI_OPS, 8'h00, q, ok);
	endtask
endmodule

// ===== sscr_period_timer.sv
// Millisecond tick and sampling period timer.
// Assumes clk_sys at the package rate; restart comes from same-clock logic.
`timescale 1ns/1ns
module sscr_period_timer #(
	parameter int MS_CYCLES = sscr_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Control
	input  wire logic [7:0] period_code,
	input  wire logic       restart,
	// Events
	output logic            ms_tick,
	output logic            period_done
);
	logic [31:0]          tick_cnt_reg;
	logic [31:0]          tick_cnt_next;
	sscr_pkg::sscr_ms_t   ms_cnt_reg;
	sscr_pkg::sscr_ms_t   ms_cnt_next;
	logic                 ms_tick_next;
	logic                 period_done_next;

	always_comb
	begin
		tick_cnt_next    = tick_cnt_reg + 32'h1;
		ms_cnt_next      = ms_cnt_reg;
		ms_tick_next     = 1'b0;
		period_done_next = 1'b0;
		if (restart)
		begin
			tick_cnt_next = 32'h0;
			ms_cnt_next   = '0;
		end
		else if (tick_cnt_reg == 32'(MS_CYCLES - 1))
		begin
			tick_cnt_next = 32'h0;
			ms_tick_next  = 1'b1;
			// One measurement per elapsed period
			if (ms_cnt_reg + 10'h1 >= sscr_pkg::period_ms(period_code))
			begin
				ms_cnt_next      = '0;
				period_done_next = 1'b1;
			end
			else
				ms_cnt_next = ms_cnt_reg + 10'h1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tick_cnt_reg <= 32'h0;
			ms_cnt_reg   <= '0;
			ms_tick      <= 1'b0;
			period_done  <= 1'b0;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_next;
			ms_cnt_reg   <= ms_cnt_next;
			ms_tick      <= ms_tick_next;
			period_done  <= period_done_next;
		end
	end
endmodule

// ===== sscr_pkg.sv
// Constants, codes and decode functions for the sampling schedule registers.
// Assumes a single 125 MHz system clock.
package sscr_pkg;
	// Timing
	localparam int CLK_PERIOD_NS  = 8;
	localparam int MS_NS          = 1000000;
	localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
	localparam int HOLD_TIMEOUT_MS = 200;

	// Register addresses
	localparam logic [15:0] ADDR_SPI_OPS = 16'h0038;
	localparam logic [15:0] ADDR_PERIOD  = 16'h0050;
	localparam logic [15:0] ADDR_STINT   = 16'h0051;
	localparam logic [15:0] ADDR_AUX     = 16'h0052;

	// Fields and reset values
	localparam int HOLD_BIT = 2;
	localparam int AUX_W    = 3;
	localparam logic [7:0] OPS_RST    = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'h04;
	localparam logic [7:0] STINT_RST  = 8'hFF;
	localparam logic [2:0] AUX_RST    = 3'h0;
	localparam logic [2:0] AUX_SUPPLY_IDLE_HIGH = 3'h4;
	localparam logic [2:0] AUX_SUPPLY_IDLE_LOW  = 3'h5;

	// Sub-bus module select within an address
	localparam int SUBMOD_LSB = 4;
	localparam int SUBMOD_W   = 4;

	// Sampling periods in ms
	typedef logic [9:0] sscr_ms_t;
	localparam sscr_ms_t PER_MS_0 = 10'h00A;
	localparam sscr_ms_t PER_MS_1 = 10'h014;
	localparam sscr_ms_t PER_MS_2 = 10'h028;
	localparam sscr_ms_t PER_MS_3 = 10'h046;
	localparam sscr_ms_t PER_MS_4 = 10'h087;
	localparam sscr_ms_t PER_MS_5 = 10'h1FE;
	localparam sscr_ms_t PER_MS_6 = 10'h3E8;

	function automatic sscr_ms_t period_ms(input logic [7:0] code);
		case (code)
			8'h00: return PER_MS_0;
			8'h01: return PER_MS_1;
			8'h02: return PER_MS_2;
			8'h03: return PER_MS_3;
			8'h04: return PER_MS_4;
			8'h05: return PER_MS_5;
			default: return PER_MS_6;
		endcase
	endfunction

	function automatic logic [SUBMOD_W-1:0] submod_of(input logic [15:0] addr);
		return addr[SUBMOD_LSB +: SUBMOD_W];
	endfunction
endpackage

// ===== sscr_regs.sv
// Sampling schedule configuration registers with hold, timeout and aux pin.
// Assumes SPI framing and processor logic on clk_sys; requests held until granted.
`timescale 1ns/1ns
// Function
// - While the hold bit (bit 2) is set the processor is stalled and SPI owns the bus.
// - With the hold bit clear, SPI is granted only if the processor is not on its sub-bus.
// - A measurement starts at the end of every sampling period outside a hold; periods ending in a hold give one start after it.
// - Period codes 0..6 give 10,20,40,70,135,510,1000 ms; 7..255 act as 1000 ms.
// - Reset loads period code 4, a 135 ms period.
// - A new period code clears the pressure FIFO once SPI transfers are done.
// - A zero self-test interval disables the periodic self-test.
// - A self-test interval N of 1..255 runs the self-test every N periods.
// - Aux code 100 drives an idle-high supply enable, 101 idle-low; others disable the pin.
// - Clearing the hold ends the wait, runs pending commands, then resumes the schedule.
// - A hold never cleared times out into sleep and discards pending commands.
module sscr_regs #(
	parameter int MS_CYCLES       = sscr_pkg::MS_CYCLES,
	parameter int HOLD_TIMEOUT_MS = sscr_pkg::HOLD_TIMEOUT_MS
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// SPI register access
	input  wire logic        spi_req,
	input  wire logic        spi_we,
	input  wire logic [15:0] spi_addr,
	input  wire logic [7:0]  spi_wdata,
	input  wire logic        spi_xfer_active,
	output logic             spi_grant,
	output logic [7:0]       spi_rdata,
	// Internal processor
	input  wire logic        cpu_req,
	input  wire logic [15:0] cpu_addr,
	output logic             cpu_grant,
	output logic             cpu_stall,
	// Schedule events
	output logic             meas_start,
	output logic             selftest_start,
	output logic             fifo_clear,
	output logic             cmd_exec,
	output logic             cmd_discard,
	output logic             sleep_req,
	output logic             wait_state,
	// Aux pin
	input  wire logic        supply_enable_req,
	output logic             aux_pin_o,
	output logic             aux_pin_oe
);
	typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_RESUME} sscr_state_t;

	sscr_state_t            state_reg, state_next;
	logic                   hold_reg, hold_next;
	logic [7:0]             period_reg, period_next;
	logic [7:0]             stint_reg, stint_next;
	logic [2:0]             aux_reg, aux_next;
	logic [7:0]             st_cnt_reg, st_cnt_next;
	logic                   clr_pend_reg, clr_pend_next;
	logic                   meas_pend_reg, meas_pend_next;
	logic                   st_pend_reg, st_pend_next;
	logic [15:0]            to_cnt_reg, to_cnt_next;
	logic [7:0]             rdata_next;
	logic                   meas_next, st_next, fclr_next;
	logic                   exec_next, disc_next, sleep_next;
	logic                   pin_o_next, pin_oe_next;
	logic                   wr, wr_period, wr_stint;
	logic                   ms_tick, period_done, st_fire;

	sscr_period_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.period_code (period_reg),
		.restart     (wr_period),
		.ms_tick     (ms_tick),
		.period_done (period_done)
	);

	sscr_bus_arbiter u_arb (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.hold      (hold_reg),
		.cpu_req   (cpu_req),
		.cpu_addr  (cpu_addr),
		.cpu_grant (cpu_grant),
		.spi_req   (spi_req),
		.spi_addr  (spi_addr),
		.spi_grant (spi_grant)
	);

	// Register file and read path
	always_comb
	begin
		wr         = spi_grant && spi_we;
		wr_period  = wr && (spi_addr == sscr_pkg::ADDR_PERIOD);
		wr_stint   = wr && (spi_addr == sscr_pkg::ADDR_STINT);
		period_next = wr_period ? spi_wdata : period_reg;
		stint_next  = wr_stint ? spi_wdata : stint_reg;
		aux_next    = aux_reg;
		if (wr && spi_addr == sscr_pkg::ADDR_AUX)
			aux_next = spi_wdata[sscr_pkg::AUX_W-1:0];
		rdata_next = spi_rdata;
		if (spi_grant && !spi_we)
		begin
			unique case (spi_addr)
				sscr_pkg::ADDR_SPI_OPS: rdata_next = 8'(hold_reg) << sscr_pkg::HOLD_BIT;
				sscr_pkg::ADDR_PERIOD:  rdata_next = period_reg;
				sscr_pkg::ADDR_STINT:   rdata_next = stint_reg;
				sscr_pkg::ADDR_AUX:     rdata_next = {5'h00, aux_reg};
				default:                rdata_next = 8'h00;
			endcase
		end
	end

	// Hold and wait state
	always_comb
	begin
		state_next = state_reg;
		hold_next  = hold_reg;
		to_cnt_next = to_cnt_reg;
		exec_next  = 1'b0;
		disc_next  = 1'b0;
		sleep_next = 1'b0;
		if (wr && spi_addr == sscr_pkg::ADDR_SPI_OPS)
			hold_next = spi_wdata[sscr_pkg::HOLD_BIT];
		unique case (state_reg)
			ST_RUN:
			begin
				to_cnt_next = 16'h0;
				if (hold_reg)
					state_next = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (!hold_reg)
				begin
					state_next = ST_RESUME;
					exec_next  = 1'b1;
				end
				else if (to_cnt_reg == 16'(HOLD_TIMEOUT_MS))
				begin
					state_next = ST_RUN;
					hold_next  = 1'b0;
					disc_next  = 1'b1;
					sleep_next = 1'b1;
				end
				else if (ms_tick)
					to_cnt_next = to_cnt_reg + 16'h1;
			end
			ST_RESUME:
				state_next = ST_RUN;
		endcase
	end

	// Schedule, self-test and FIFO clear
	always_comb
	begin
		st_fire = period_done && (stint_reg != 8'h00) && (st_cnt_reg + 8'h1 >= stint_reg);
		st_cnt_next = st_cnt_reg;
		if (wr_stint || st_fire)
			st_cnt_next = 8'h00;
		else if (period_done && stint_reg != 8'h00)
			st_cnt_next = st_cnt_reg + 8'h1;
		meas_next = 1'b0;
		st_next   = 1'b0;
		meas_pend_next = meas_pend_reg || period_done;
		st_pend_next   = st_pend_reg || st_fire;
		// Periodic work waits for the hold and the pending commands
		if (state_reg == ST_RUN && !hold_reg)
		begin
			meas_next      = meas_pend_next;
			st_next        = st_pend_next;
			meas_pend_next = 1'b0;
			st_pend_next   = 1'b0;
		end
		// Set wins over the clear
		fclr_next     = clr_pend_reg && !spi_xfer_active;
		clr_pend_next = wr_period || (clr_pend_reg && spi_xfer_active);
	end

	// Aux pin
	always_comb
	begin
		pin_o_next  = 1'b0;
		pin_oe_next = 1'b0;
		if (aux_reg == sscr_pkg::AUX_SUPPLY_IDLE_HIGH)
		begin
			pin_oe_next = 1'b1;
			pin_o_next  = !supply_enable_req;
		end
		else if (aux_reg == sscr_pkg::AUX_SUPPLY_IDLE_LOW)
		begin
			pin_oe_next = 1'b1;
			pin_o_next  = supply_enable_req;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_reg      <= ST_RUN;
			hold_reg       <= sscr_pkg::OPS_RST[sscr_pkg::HOLD_BIT];
			period_reg     <= sscr_pkg::PERIOD_RST;
			stint_reg      <= sscr_pkg::STINT_RST;
			aux_reg        <= sscr_pkg::AUX_RST;
			st_cnt_reg     <= 8'h00;
			clr_pend_reg   <= 1'b0;
			meas_pend_reg  <= 1'b0;
			st_pend_reg    <= 1'b0;
			to_cnt_reg     <= 16'h0;
			spi_rdata      <= 8'h00;
			meas_start     <= 1'b0;
			selftest_start <= 1'b0;
			fifo_clear     <= 1'b0;
			cmd_exec       <= 1'b0;
			cmd_discard    <= 1'b0;
			sleep_req      <= 1'b0;
			wait_state     <= 1'b0;
			cpu_stall      <= 1'b0;
			aux_pin_o      <= 1'b0;
			aux_pin_oe     <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			hold_reg       <= hold_next;
			period_reg     <= period_next;
			stint_reg      <= stint_next;
			aux_reg        <= aux_next;
			st_cnt_reg     <= st_cnt_next;
			clr_pend_reg   <= clr_pend_next;
			meas_pend_reg  <= meas_pend_next;
			st_pend_reg    <= st_pend_next;
			to_cnt_reg     <= to_cnt_next;
			spi_rdata      <= rdata_next;
			meas_start     <= meas_next;
			selftest_start <= st_next;
			fifo_clear     <= fclr_next;
			cmd_exec       <= exec_next;
			cmd_discard    <= disc_next;
			sleep_req      <= sleep_next;
			wait_state     <= (state_next == ST_WAIT);
			cpu_stall      <= hold_next;
			aux_pin_o      <= pin_o_next;
			aux_pin_oe     <= pin_oe_next;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_hold_stalls_cpu: assert property (cpu_stall |=> !cpu_grant)
		else $error("processor granted while held");
	chk_spi_conflict_wait: assert property (
		!hold_reg && cpu_req && spi_req && !spi_grant
		&& sscr_pkg::submod_of(cpu_addr) == sscr_pkg::submod_of(spi_addr) |=> !spi_grant)
		else $error("spi granted on busy sub-bus");
	chk_meas_follows_period: assert property (
		period_done && state_reg == ST_RUN && !hold_reg |=> meas_start)
		else $error("measurement missing after period");
	chk_period_reset_code: assert property (
		$past(rst) |-> period_reg == sscr_pkg::PERIOD_RST)
		else $error("period code not reset to 4");
	chk_fifo_clear_after: assert property (
		fifo_clear |-> $past(clr_pend_reg) && !$past(spi_xfer_active))
		else $error("fifo cleared during transfer");
	chk_selftest_off: assert property (
		stint_reg == 8'h00 && !st_pend_reg |=> !selftest_start)
		else $error("self-test with zero interval");
	chk_aux_disabled: assert property (
		aux_reg != sscr_pkg::AUX_SUPPLY_IDLE_HIGH && aux_reg != sscr_pkg::AUX_SUPPLY_IDLE_LOW
		|=> !aux_pin_oe)
		else $error("aux pin driven while disabled");
	chk_resume_exec: assert property (
		state_reg == ST_WAIT && !hold_reg |=> cmd_exec ##1 (state_reg == ST_RUN))
		else $error("no command run on resume");
	chk_timeout_sleep: assert property (
		cmd_discard |-> sleep_req && !cmd_exec && !cpu_stall)
		else $error("timeout without sleep");
	chk_reserved_zero: assert property (
		$past(spi_grant) && !$past(spi_we) && $past(spi_addr) == sscr_pkg::ADDR_SPI_OPS
		|-> spi_rdata[7:3] == 5'h00 && spi_rdata[1:0] == 2'h0)
		else $error("reserved bits read nonzero");
	chk_stcnt_restart: assert property (wr_stint |=> st_cnt_reg == 8'h00)
		else $error("self-test counter not restarted");
	chk_spi_hold_grant: assert property (
		hold_reg && spi_req && !spi_grant |=> spi_grant)
		else $error("spi refused while held");
	chk_aux_idle_high: assert property (
		aux_reg == sscr_pkg::AUX_SUPPLY_IDLE_HIGH
		|=> aux_pin_oe && aux_pin_o == !$past(supply_enable_req))
		else $error("aux supply enable level wrong");
	chk_fifo_clear_set: assert property (wr_period |=> clr_pend_reg)
		else $error("fifo clear request lost");

	cov_hold_resume: cover property (state_reg == ST_WAIT ##1 cmd_exec);
	cov_hold_timeout: cover property (cmd_discard);
	cov_selftest: cover property (selftest_start);
	cov_fifo_clear: cover property (fifo_clear);
	cov_spi_conflict: cover property (cpu_req && spi_req && !spi_grant && !hold_reg);
endmodule

// ===== sscr_regs_tb_top.sv
// Self-checking bench for the sampling schedule registers.
// Assumes a host model on the register port and shortened ms and timeout counts.
`timescale 1ns/1ns
module sscr_regs_tb_top;
	localparam int MSC = 10;
	localparam int HTO = 3;
	logic        clk_sys = 1'h0;
	logic        rst = 1'h1;
	logic        spi_req, spi_we, spi_xfer_active, spi_grant;
	logic [15:0] spi_addr, cpu_addr;
	logic [7:0]  spi_wdata, spi_rdata, q;
	logic        cpu_req, cpu_grant, cpu_stall, meas_start, selftest_start, fifo_clear;
	logic        cmd_exec, cmd_discard, sleep_req, wait_state;
	logic        supply_enable_req, aux_pin_o, aux_pin_oe;
	logic [5:0]  ev;
	logic [31:0] seed = 32'h00000028;
	int          miscompares = 0, checked = 0, cyc = 0, cpu_t = 0, spi_t = 0;
	int          cpu_cnt = 0, exec_cnt = 0, fifo_cnt = 0, st_cnt = 0, i, n, c0;
	bit          ok;

	always #4 clk_sys = ~clk_sys;

	sscr_regs #(.MS_CYCLES(MSC), .HOLD_TIMEOUT_MS(HTO)) sscr_regs_inst (
		.clk_sys(clk_sys), .rst(rst), .spi_req(spi_req), .spi_we(spi_we),
		.spi_addr(spi_addr), .spi_wdata(spi_wdata), .spi_xfer_active(spi_xfer_active),
		.spi_grant(spi_grant), .spi_rdata(spi_rdata), .cpu_req(cpu_req),
		.cpu_addr(cpu_addr), .cpu_grant(cpu_grant), .cpu_stall(cpu_stall),
		.meas_start(meas_start), .selftest_start(selftest_start), .fifo_clear(fifo_clear),
		.cmd_exec(cmd_exec), .cmd_discard(cmd_discard), .sleep_req(sleep_req),
		.wait_state(wait_state), .supply_enable_req(supply_enable_req),
		.aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe));

	sscr_host_model sscr_host_model_inst (
		.clk_sys(clk_sys), .spi_req(spi_req), .spi_we(spi_we), .spi_addr(spi_addr),
		.spi_wdata(spi_wdata), .spi_grant(spi_grant), .spi_rdata(spi_rdata));

	assign ev = {cpu_grant, cmd_discard & sleep_req, cmd_exec, fifo_clear, selftest_start,
		meas_start};

	// Event counters and grant times
	always @(negedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cpu_grant === 1'h1) cpu_t <= cyc;
		if (spi_grant === 1'h1) spi_t <= cyc;
		if (cpu_grant === 1'h1) cpu_cnt <= cpu_cnt + 1;
		if (cmd_exec === 1'h1) exec_cnt <= exec_cnt + 1;
		if (fifo_clear === 1'h1) fifo_cnt <= fifo_cnt + 1;
		if (selftest_start === 1'h1) st_cnt <= st_cnt + 1;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int per_ms(input int c);
		case (c)
			0: return 10;
			1: return 20;
			2: return 40;
			3: return 70;
			4: return 135;
			5: return 510;
			default: return 1000;
		endcase
	endfunction

	function automatic logic [15:0] exp_aux(input int c, input logic s);
		if (c == 4) return {15'h0001, ~s};
		if (c == 5) return {15'h0001, s};
		return 16'h0000;
	endfunction

	task automatic test_done();
		$display("Mismatches %0d, comparisons %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		checked++;
		if (got != exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bounded wait for one event, counting cycles
	task automatic wait_ev(input int e, input int lim, output int k);
		k = 0;
		checked++;
		do
		begin
			@(negedge clk_sys);
			k++;
		end
		while (ev[e] !== 1'h1 && k < lim);
		if (ev[e] !== 1'h1)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, k, lim);
			test_done();
		end
	endtask

	task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d);
		sscr_host_model_inst.xfer(we, a, d, q, ok);
		chk_v(ok, 1'h1);
		if (!ok)
			test_done();
	endtask

	initial
	begin
		spi_xfer_active   = 1'h0;
		cpu_req           = 1'h0;
		cpu_addr          = 16'h0055;
		supply_enable_req = 1'h0;
		repeat (20) @(negedge clk_sys);
		rst = 1'h0;
		// Reset values, unmapped place, reserved bits
		acc(1'h0, sscr_pkg::ADDR_PERIOD, 8'h00);
		chk_v(q, 8'h04);
		acc(1'h0, sscr_pkg::ADDR_STINT, 8'h00);
		chk_v(q, 8'hFF);
		acc(1'h0, sscr_pkg::ADDR_SPI_OPS, 8'h00);
		chk_v({q, cpu_stall}, 16'h0000);
		acc(1'h0, 16'h0040, 8'h00);
		chk_v(q, 8'h00);
		acc(1'h1, sscr_pkg::ADDR_SPI_OPS, 8'hFB);
		acc(1'h0, sscr_pkg::ADDR_SPI_OPS, 8'h00);
		chk_v(q, 8'h00);
		acc(1'h1, sscr_pkg::ADDR_STINT, 8'(rnd()));
		acc(1'h0, sscr_pkg::ADDR_STINT, 8'h00);
		chk_v(q, seed[7:0]);
		// Aux pin codes with reserved bits set
		for (i = 0; i < 8; i++)
		begin
			acc(1'h1, sscr_pkg::ADDR_AUX, 8'hF8 | i[7:0]);
			acc(1'h0, sscr_pkg::ADDR_AUX, 8'h00);
			chk_v(q, i[7:0]);
			supply_enable_req = 1'(rnd());
			repeat (2) @(negedge clk_sys);
			chk_v({aux_pin_oe, aux_pin_o}, exp_aux(i, supply_enable_req));
		end
		// Period between measurements for every code, one random high code
		for (i = 0; i < 8; i++)
		begin
			c0 = (i < 7) ? i : 7 + rnd() % 249;
			acc(1'h1, sscr_pkg::ADDR_PERIOD, c0[7:0]);
			wait_ev(0, 11000, n);
			wait_ev(0, 11000, n);
			chk_n(n, per_ms(c0) * MSC);
		end
		// Clear of the pressure store waits for transfers to end
		spi_xfer_active = 1'h1;
		acc(1'h1, sscr_pkg::ADDR_PERIOD, 8'h00);
		c0 = fifo_cnt;
		repeat (10) @(negedge clk_sys);
		chk_n(fifo_cnt, c0);
		spi_xfer_active = 1'h0;
		wait_ev(2, 4, n);
		// Self-test every second period, then never
		acc(1'h1, sscr_pkg::ADDR_STINT, 8'h02);
		wait_ev(1, 400, n);
		wait_ev(1, 400, n);
		chk_n(n, 2 * per_ms(0) * MSC);
		acc(1'h1, sscr_pkg::ADDR_STINT, 8'h00);
		c0 = st_cnt;
		repeat (500) @(negedge clk_sys);
		chk_n(st_cnt, c0);
		// Processor wins its own sub-bus without hold
		fork
			begin
				cpu_req = 1'h1;
				wait_ev(5, 20, n);
				cpu_req = 1'h0;
			end
			acc(1'h0, sscr_pkg::ADDR_PERIOD, 8'h00);
		join
		chk_n(spi_t > cpu_t, 1);
		// Hold stalls the processor, release runs pending commands
		acc(1'h1, sscr_pkg::ADDR_SPI_OPS, 8'h04);
		repeat (2) @(negedge clk_sys);
		chk_v({cpu_stall, wait_state}, 16'h0003);
		cpu_req = 1'h1;
		c0 = cpu_cnt;
		acc(1'h0, sscr_pkg::ADDR_PERIOD, 8'h00);
		chk_v(q, 8'h00);
		repeat (5) @(negedge clk_sys);
		chk_n(cpu_cnt, c0);
		c0 = exec_cnt;
		sscr_host_model_inst.release_hold(ok);
		chk_v(ok, 1'h1);
		if (!ok)
			test_done();
		wait_ev(5, 20, n);
		cpu_req = 1'h0;
		chk_n(exec_cnt, c0 + 1);
		// Hold never released times out into sleep
		acc(1'h1, sscr_pkg::ADDR_SPI_OPS, 8'h04);
		wait_ev(4, HTO * MSC + 40, n);
		acc(1'h0, sscr_pkg::ADDR_SPI_OPS, 8'h00);
		chk_v({q, cpu_stall}, 16'h0000);
		chk_n(exec_cnt, c0 + 1);
		// Second reset in mid-run
		rst = 1'h1;
		repeat (2) @(negedge clk_sys);
		rst = 1'h0;
		acc(1'h0, sscr_pkg::ADDR_PERIOD, 8'h00);
		chk_v(q, 8'h04);
		test_done();
	end
endmodule
